/* tsa_pkg.sv */
// package: constants and types for the timeslot access unit
// Functional notes
// - a parity violation may overwrite slot data in an unspecified pattern
// - loop-back and switching work when the read and write registers hold the same place in opposite pairs
// - other read/write pairings may loop, mis-monitor or drive wrong data
// - with input and output disabled, a read returns the previous programming
// - once output is enabled, the latest written value becomes readable
// - one flag marks intermediate access, another marks failed access
package tsa_pkg;
  localparam int          TSA_NUM_REGS   = 4;
  localparam int          TSA_DATA_W     = 8;
  localparam int          TSA_SLOT_W     = 4;
  localparam int          TSA_NUM_SLOTS  = 12;
  localparam logic [7:0]  TSA_DATA_RST   = 8'hFF;
  localparam logic [3:0]  TSA_SLOT_RST   = 4'h0;
  // register index: bit0 selects second of pair, bit1 selects pair 2
  localparam logic [1:0]  TSA_IDX_P1_FIRST  = 2'h0;
  localparam logic [1:0]  TSA_IDX_P1_SECOND = 2'h1;
  localparam logic [1:0]  TSA_IDX_P2_FIRST  = 2'h2;
  localparam logic [1:0]  TSA_IDX_P2_SECOND = 2'h3;
  // control field positions: per register input enable and output enable
  localparam int          TSA_CTL_IN_POS  = 0;
  localparam int          TSA_CTL_OUT_POS = 1;
  localparam logic [1:0]  TSA_CTL_RST     = 2'h0;
  typedef enum logic [1:0] {
    TSA_ST_IDLE   = 2'b00,
    TSA_ST_ACTIVE = 2'b01,
    TSA_ST_DONE   = 2'b10
  } tsa_state_t;
endpackage

/* tsa_access_reg.sv */
// module: one access register with shadow write and read-back staging
`timescale 1ns/1ps
`default_nettype none
module tsa_access_reg
  import tsa_pkg::*;
#(
  parameter int DATA_W = TSA_DATA_W
)
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic              wr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic              in_en_i,
  input  wire logic              out_en_i,
  input  wire logic              cap_i,
  input  wire logic [DATA_W-1:0] cap_data_i,
  output logic      [DATA_W-1:0] prog_o,
  output logic      [DATA_W-1:0] rd_o
);
  if (DATA_W < 1)
  begin : g_bad_width
    $error("tsa_access_reg: DATA_W must be positive");
  end

  logic [DATA_W-1:0] prog_reg;
  logic [DATA_W-1:0] prog_next;
  logic [DATA_W-1:0] view_reg;
  logic [DATA_W-1:0] view_next;

  // ------------------------------------------------------------
  // shadow and visible copy
  // ------------------------------------------------------------
  always_comb
  begin
    prog_next = prog_reg;
    view_next = view_reg;
    if (wr_i)
    begin
      prog_next = wr_data_i;
    end
    // the visible copy only follows a write while some path is live
    if (cap_i && in_en_i)
    begin
      view_next = cap_data_i;
    end
    else if (out_en_i)
    begin
      view_next = prog_next;
    end
    else if (in_en_i && wr_i)
    begin
      view_next = wr_data_i;
    end
    // both paths off: keep previous programming visible
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      prog_reg <= DATA_W'(TSA_DATA_RST);
      view_reg <= DATA_W'(TSA_DATA_RST);
    end
    else
    begin
      prog_reg <= prog_next;
      view_reg <= view_next;
    end
  end

  assign prog_o = prog_reg;
  assign rd_o   = view_reg;
endmodule
`default_nettype wire

/* tsa_core.sv */
// module: timeslot access unit with four access registers on a serial bus
`timescale 1ns/1ps
`default_nettype none
module tsa_core
  import tsa_pkg::*;
#(
  parameter int NUM_REGS  = TSA_NUM_REGS,
  parameter int DATA_W    = TSA_DATA_W,
  parameter int SLOT_W    = TSA_SLOT_W,
  parameter int NUM_SLOTS = TSA_NUM_SLOTS
)
(
  input  wire logic                         ref_clk_i,
  input  wire logic                         rst_i,
  // host side
  input  wire logic                         host_wr_i,
  input  wire logic [1:0]                   host_idx_i,
  input  wire logic [DATA_W-1:0]            host_wdata_i,
  input  wire logic                         host_rd_i,
  output logic      [DATA_W-1:0]            host_rdata_o,
  output logic                              host_rvalid_o,
  // per register control: {out_en, in_en}, and slot/direction select
  input  wire logic [2*NUM_REGS-1:0]        reg_ctl_i,
  input  wire logic [SLOT_W*NUM_REGS-1:0]   reg_slot_i,
  input  wire logic [NUM_REGS-1:0]          reg_dir_up_i,
  // serial bus side, one byte per timeslot
  input  wire logic                         slot_strobe_i,
  input  wire logic [SLOT_W-1:0]            slot_num_i,
  input  wire logic [DATA_W-1:0]            downstream_line_i,
  input  wire logic [DATA_W-1:0]            upstream_line_i,
  output logic      [DATA_W-1:0]            downstream_line_o,
  output logic                              downstream_line_oe_o,
  output logic      [DATA_W-1:0]            upstream_line_o,
  output logic                              upstream_line_oe_o,
  // access flags, one cycle each
  output logic                              intermediate_access_flag_o,
  output logic                              failed_access_flag_o
);
  // ------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------
  // the host index is two bits wide, so exactly four registers are served
  if (NUM_REGS != 4)
  begin : g_bad_regs
    $error("tsa_core: NUM_REGS must be 4");
  end
  if (NUM_SLOTS > (1 << SLOT_W))
  begin : g_bad_slots
    $error("tsa_core: SLOT_W too narrow");
  end
  if (DATA_W < 1)
  begin : g_bad_width
    $error("tsa_core: DATA_W must be positive");
  end

  logic [DATA_W-1:0] prog_w [NUM_REGS];
  logic [DATA_W-1:0] rd_w   [NUM_REGS];
  logic [NUM_REGS-1:0] hit_w;
  logic [NUM_REGS-1:0] drv_w;

  // ------------------------------------------------------------
  // access registers
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++)
    begin : g_reg
      logic [SLOT_W-1:0] slot_w;
      assign slot_w = reg_slot_i[g*SLOT_W +: SLOT_W];
      // any register may take any slot; no parity check in hardware
      assign hit_w[g] = slot_strobe_i && (slot_num_i == slot_w);
      assign drv_w[g] = hit_w[g] && reg_ctl_i[2*g + TSA_CTL_OUT_POS];
      tsa_access_reg #(
        .DATA_W (DATA_W)
      ) u_reg (
        .ref_clk_i  (ref_clk_i),
        .rst_i      (rst_i),
        .wr_i       (host_wr_i && (host_idx_i == 2'(g))),
        .wr_data_i  (host_wdata_i),
        .in_en_i    (reg_ctl_i[2*g + TSA_CTL_IN_POS]),
        .out_en_i   (reg_ctl_i[2*g + TSA_CTL_OUT_POS]),
        .cap_i      (hit_w[g]),
        .cap_data_i (reg_dir_up_i[g] ? upstream_line_i : downstream_line_i),
        .prog_o     (prog_w[g]),
        .rd_o       (rd_w[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // bus drive and flags
  // ------------------------------------------------------------
  logic [DATA_W-1:0] dd_reg;
  logic [DATA_W-1:0] dd_next;
  logic              dd_oe_reg;
  logic              dd_oe_next;
  logic [DATA_W-1:0] du_reg;
  logic [DATA_W-1:0] du_next;
  logic              du_oe_reg;
  logic              du_oe_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic              rvalid_reg;
  logic              rvalid_next;
  logic              inter_reg;
  logic              inter_next;
  logic              fail_reg;
  logic              fail_next;
  tsa_state_t        state_reg;
  tsa_state_t        state_next;
  int unsigned       dd_cnt;
  int unsigned       du_cnt;

  always_comb
  begin
    dd_next     = '0;
    dd_oe_next  = 1'b0;
    du_next     = '0;
    du_oe_next  = 1'b0;
    dd_cnt      = 0;
    du_cnt      = 0;
    state_next  = state_reg;
    inter_next  = 1'b0;
    fail_next   = 1'b0;
    rvalid_next = host_rd_i;
    // read data is held between reads so a late sampler still sees it
    rdata_next  = host_rd_i ? rd_w[host_idx_i] : rdata_reg;
    // lower index wins a collision; the data seen by others is then undefined
    for (int i = NUM_REGS - 1; i >= 0; i--)
    begin
      if (drv_w[i])
      begin
        if (reg_dir_up_i[i])
        begin
          du_next    = prog_w[i];
          du_oe_next = 1'b1;
          du_cnt++;
        end
        else
        begin
          dd_next    = prog_w[i];
          dd_oe_next = 1'b1;
          dd_cnt++;
        end
      end
    end
    unique case (state_reg)
      TSA_ST_IDLE:
      begin
        if (|hit_w)
        begin
          state_next = TSA_ST_ACTIVE;
        end
      end
      TSA_ST_ACTIVE:
      begin
        if (!slot_strobe_i)
        begin
          state_next = TSA_ST_DONE;
        end
      end
      TSA_ST_DONE:
      begin
        state_next = TSA_ST_IDLE;
      end
      default:
      begin
        state_next = TSA_ST_IDLE;
      end
    endcase
    // a hit in DONE flags but still falls back to idle, so a run of slots flags every other one
    // intermediate: a hit while a prior access is still open
    if ((|hit_w) && (state_reg != TSA_ST_IDLE))
    begin
      inter_next = 1'b1;
    end
    // failed: two registers driving one direction in one slot
    if ((dd_cnt > 1) || (du_cnt > 1))
    begin
      fail_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      dd_reg     <= '0;
      dd_oe_reg  <= 1'b0;
      du_reg     <= '0;
      du_oe_reg  <= 1'b0;
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
      inter_reg  <= 1'b0;
      fail_reg   <= 1'b0;
      state_reg  <= TSA_ST_IDLE;
    end
    else
    begin
      dd_reg     <= dd_next;
      dd_oe_reg  <= dd_oe_next;
      du_reg     <= du_next;
      du_oe_reg  <= du_oe_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      inter_reg  <= inter_next;
      fail_reg   <= fail_next;
      state_reg  <= state_next;
    end
  end

  assign downstream_line_o          = dd_reg;
  assign downstream_line_oe_o       = dd_oe_reg;
  assign upstream_line_o            = du_reg;
  assign upstream_line_oe_o         = du_oe_reg;
  assign host_rdata_o               = rdata_reg;
  assign host_rvalid_o              = rvalid_reg;
  assign intermediate_access_flag_o = inter_reg;
  assign failed_access_flag_o       = fail_reg;
endmodule
`default_nettype wire

/* tsa_props.sv */
// checker: port-level assertions for the timeslot access unit
`timescale 1ns/1ps
`default_nettype none
module tsa_props
  import tsa_pkg::*;
#(
  parameter int DATA_W = TSA_DATA_W
)
(
  input wire logic              ref_clk_i,
  input wire logic              rst_i,
  input wire logic              host_rd_i,
  input wire logic [DATA_W-1:0] host_rdata_o,
  input wire logic              host_rvalid_o,
  input wire logic              slot_strobe_i,
  input wire logic              downstream_line_oe_o,
  input wire logic              upstream_line_oe_o,
  input wire logic              intermediate_access_flag_o,
  input wire logic              failed_access_flag_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  rd_answer_a: assert property (host_rd_i |=> host_rvalid_o)
    else $error("read not answered next cycle");
  rvalid_cause_a: assert property (host_rvalid_o |-> $past(host_rd_i))
    else $error("read valid without a read");
  rdata_hold_a: assert property (!host_rvalid_o |-> $stable(host_rdata_o))
    else $error("read data moved without a read");
  dn_drive_a: assert property (!slot_strobe_i |=> !downstream_line_oe_o)
    else $error("downstream driven outside a slot");
  up_drive_a: assert property (!slot_strobe_i |=> !upstream_line_oe_o)
    else $error("upstream driven outside a slot");
  fail_flag_a: assert property (!slot_strobe_i |=> !failed_access_flag_o)
    else $error("failed flag outside a slot");
  mid_flag_a: assert property (!slot_strobe_i |=> !intermediate_access_flag_o)
    else $error("intermediate flag outside a slot");
endmodule
bind tsa_core tsa_props #(.DATA_W(DATA_W)) u_props (.ref_clk_i, .rst_i, .host_rd_i,
  .host_rdata_o, .host_rvalid_o, .slot_strobe_i, .downstream_line_oe_o,
  .upstream_line_oe_o, .intermediate_access_flag_o, .failed_access_flag_o);
`default_nettype wire

/* tsa_bus_dev.sv */
// partner: bus device stepping through the timeslots, one strobe per slot
`timescale 1ns/1ps
`default_nettype none
module tsa_bus_dev
  import tsa_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  run_i,
  output logic                       slot_strobe_o,
  output logic      [TSA_SLOT_W-1:0] slot_num_o,
  output logic      [TSA_DATA_W-1:0] dn_o,
  output logic      [TSA_DATA_W-1:0] up_o
);
  int k;
  logic live;
  initial
  begin
    k = 0;
    slot_strobe_o = 1'b0;
    slot_num_o = TSA_SLOT_RST;
    dn_o = 8'h00;
    up_o = 8'h00;
  end
  // between slots the bytes invert so a stale value never passes as valid
  always @(posedge ref_clk_i)
  begin
    // run is taken at the edge, so a start written in the same step cannot race
    live = run_i;
    #2;
    if (live && !slot_strobe_o)
    begin
      slot_strobe_o = 1'b1;
      slot_num_o = k[3:0];
      dn_o = {4'hA, k[3:0]};
      up_o = {4'h5, k[3:0]};
      k = (k + 1) % TSA_NUM_SLOTS;
    end
    else
    begin
      slot_strobe_o = 1'b0;
      dn_o = ~dn_o;
      up_o = ~up_o;
    end
  end
endmodule
`default_nettype wire

/* tb_top.sv */
// testbench: host model against the timeslot access unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tsa_pkg::*;
  logic       ref_clk_i, rst_i, host_wr_i, host_rd_i, host_rvalid_o, run;
  logic       slot_strobe_i, dn_oe, up_oe, mid_flag, fail_flag;
  logic [1:0] host_idx_i;
  logic [3:0] slot_num_i, reg_dir_up_i;
  logic [7:0] host_wdata_i, host_rdata_o, reg_ctl_i, dn_i, up_i, dn_o, up_o, v;
  logic [15:0] reg_slot_i;
  int         err_total, total_checks, seed, cyc, i, g, s, r, w;
  int         wrv[4], vis[4], pr[4], pw[4];
  tsa_core dut (.ref_clk_i, .rst_i, .host_wr_i, .host_idx_i, .host_wdata_i, .host_rd_i,
    .host_rdata_o, .host_rvalid_o, .reg_ctl_i, .reg_slot_i, .reg_dir_up_i, .slot_strobe_i,
    .slot_num_i, .downstream_line_i(dn_i), .upstream_line_i(up_i),
    .downstream_line_o(dn_o), .downstream_line_oe_o(dn_oe), .upstream_line_o(up_o),
    .upstream_line_oe_o(up_oe), .intermediate_access_flag_o(mid_flag),
    .failed_access_flag_o(fail_flag));
  tsa_bus_dev bus (.ref_clk_i, .run_i(run), .slot_strobe_o(slot_strobe_i),
    .slot_num_o(slot_num_i), .dn_o(dn_i), .up_o(up_i));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input int x, input logic [7:0] d);
    @(posedge ref_clk_i);
    #2;
    host_idx_i = 2'(x);
    host_wdata_i = d;
    host_wr_i = 1'b1;
    @(posedge ref_clk_i);
    #2;
    host_wr_i = 1'b0;
    wrv[x] = d;
    if (reg_ctl_i[2*x+:2] != 2'h0)
      vis[x] = d;
  endtask
  task automatic rd(input int x);
    @(posedge ref_clk_i);
    #2;
    host_idx_i = 2'(x);
    host_rd_i = 1'b1;
    @(posedge ref_clk_i);
    #1;
    chk({7'h00, host_rvalid_o}, 8'h01);
    chk(host_rdata_o, 8'(vis[x]));
    #1;
    host_rd_i = 1'b0;
  endtask
  task automatic cfg(input logic [7:0] c, input logic [15:0] sl, input logic [3:0] du);
    @(posedge ref_clk_i);
    #2;
    reg_ctl_i = c;
    reg_slot_i = sl;
    reg_dir_up_i = du;
    for (int q = 0; q < 4; q++)
      if (c[2*q+1])
        vis[q] = wrv[q];
  endtask
  task automatic wait_slot(input int sn);
    for (int n = 0; n < 60; n++)
    begin
      @(posedge ref_clk_i);
      if (slot_strobe_i === 1'b1 && slot_num_i === 4'(sn))
        break;
    end
    #1;
  endtask
  // ----------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------
  initial
  begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      $display("ERROR at %0t: run timed out", $time);
      close_out();
    end
  end
  initial
  begin
    seed = 22;
    cyc = 0;
    err_total = 0;
    total_checks = 0;
    pr = '{0, 1, 2, 3};
    pw = '{2, 3, 0, 1};
    {rst_i, run, host_wr_i, host_rd_i, host_idx_i} = 6'h20;
    {host_wdata_i, reg_ctl_i, reg_dir_up_i, reg_slot_i} = 36'h0;
    for (g = 0; g < 4; g++)
      {wrv[g], vis[g]} = {32'hFF, 32'hFF};
    repeat (10) @(posedge ref_clk_i);
    #2;
    rst_i = 1'b0;
    run = 1'b1;
    for (g = 0; g < 4; g++)
      wr(g, {1'b0, 7'($random(seed))});
    for (g = 0; g < 4; g++)
      rd(g);
    cfg(8'hAA, 16'h0000, 4'h0);
    for (g = 0; g < 4; g++)
      rd(g);
    // every legal read/write pairing, on odd and even slots alike
    for (i = 0; i < 4; i++)
    begin
      r = pr[i];
      w = pw[i];
      s = 3 * i + 2;
      v = {2'h1, 6'($random(seed))};
      cfg(8'(1 << (2*r)) | 8'(1 << (2*w+1)), 16'(s << 4*r) | 16'(s << 4*w), 4'(1 << w));
      wr(w, v);
      wait_slot(s);
      chk({7'h00, up_oe}, 8'h01);
      chk(up_o, v);
      vis[r] = 8'hA0 | s;
      rd(r);
    end
    // two registers driving one slot: lowest index keeps the line
    cfg(8'h0A, 16'h0077, 4'h0);
    wr(0, 8'h3C);
    wr(1, 8'hC3);
    wait_slot(7);
    chk({7'h00, fail_flag}, 8'h01);
    chk({7'h00, dn_oe}, 8'h01);
    chk(dn_o, 8'h3C);
    // neighbouring slots: the second hit lands while the first access is open
    cfg(8'h05, 16'h0043, 4'h2);
    wait_slot(3);
    chk({7'h00, mid_flag}, 8'h00);
    wait_slot(4);
    chk({7'h00, mid_flag}, 8'h01);
    chk({7'h00, fail_flag}, 8'h00);
    vis[0] = 8'hA3;
    vis[1] = 8'h54;
    rd(0);
    rd(1);
    wr(0, {1'b1, 7'($random(seed))});
    rd(0);
    close_out();
  end
endmodule
`default_nettype wire
